// file: core/sorm_ctrl.sv
// Safety output restart, feedback monitor, muting and AHB-Lite registers.
// Assumes field and lockout flags from the optics core, synchronous to hclk.
`timescale 1ns/1ps
module sorm_ctrl #(
  parameter int DEB_CYC  = sorm_pkg::SORM_DEB_CYC,
  parameter int MWIN_CYC = sorm_pkg::SORM_MUTE_WIN_CYC,
  parameter int OVR_CYC  = sorm_pkg::SORM_OVR_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        field_blocked,
  input  wire logic        lockout,
  input  wire logic        restart_button,
  input  wire logic        contactor_feedback_loop,
  input  wire logic [3:0]  muting_sensor,
  input  wire logic        override_key,
  output logic [1:0]       safety_output_pair,
  output logic             aux_output,
  output logic             muting_lamp,
  output logic             irq
);
  import sorm_pkg::*;

  localparam int NIN = 6;
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int MW = $clog2(MWIN_CYC + 1);
  localparam int OW = $clog2(OVR_CYC + 1);

  // Raw inputs bundled for one filter structure
  logic [NIN-1:0] raw;
  assign raw = {muting_sensor, contactor_feedback_loop, restart_button};

  // Two-flop synchroniser then a stability counter per input
  logic [NIN-1:0] s1_ff, s2_ff, deb_ff, nxt_deb;
  logic [DW-1:0]  cnt_ff [NIN];
  logic [DW-1:0]  nxt_cnt [NIN];
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_deb
      always_comb begin
        nxt_cnt[gi] = cnt_ff[gi];
        nxt_deb[gi] = deb_ff[gi];
        if (s2_ff[gi] == deb_ff[gi]) begin
          nxt_cnt[gi] = '0;
        end else if (cnt_ff[gi] == DW'(DEB_CYC - 1)) begin
          nxt_cnt[gi] = '0;
          nxt_deb[gi] = s2_ff[gi];
        end else begin
          nxt_cnt[gi] = cnt_ff[gi] + 1'b1;
        end
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_ff[gi] <= '0;
        end else begin
          cnt_ff[gi] <= nxt_cnt[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      deb_ff <= '0;
    end else begin
      s1_ff  <= raw;
      s2_ff  <= s1_ff;
      deb_ff <= nxt_deb;
    end
  end

  logic btn, fb_closed;
  logic [3:0] ms;
  assign btn       = deb_ff[0];
  assign fb_closed = deb_ff[1];
  assign ms        = deb_ff[5:2];

  // Control register
  logic [3:0] ctrl_ff, nxt_ctrl;
  logic manual_mode, four_sens, aux_mode, ovr_en;
  assign manual_mode = ctrl_ff[SORM_CTRL_MANUAL_BIT];
  assign four_sens   = ctrl_ff[SORM_CTRL_FOURSEN_BIT];
  assign aux_mode    = ctrl_ff[SORM_CTRL_AUXMODE_BIT];
  assign ovr_en      = ctrl_ff[SORM_CTRL_OVR_BIT];

  // Two logical muting sensors; in four-sensor mode pairs are ORed
  logic mute_a, mute_b;
  assign mute_a = ms[0] | (four_sens & ms[2]);
  assign mute_b = ms[1] | (four_sens & ms[3]);

  // Muting sequencer
  sorm_mute_t  mst_ff, nxt_mst;
  logic [MW-1:0] mwin_ff, nxt_mwin;
  logic [OW-1:0] ovr_ff, nxt_ovr;
  logic        first_a_ff, nxt_first_a;
  logic        muted, ovr_active, ev_mute, ev_bad;
  assign muted      = (mst_ff == SORM_M_MUTED);
  assign ovr_active = (ovr_ff != '0);
  always_comb begin
    nxt_mst     = mst_ff;
    nxt_mwin    = mwin_ff;
    nxt_first_a = first_a_ff;
    nxt_ovr     = ovr_active ? ovr_ff - 1'b1 : ovr_ff;
    ev_mute     = 1'b0;
    ev_bad      = 1'b0;
    case (mst_ff)
      SORM_M_IDLE: begin
        if (mute_a && mute_b) begin
          nxt_mst = SORM_M_BAD;
          ev_bad  = 1'b1;
        end else if (mute_a || mute_b) begin
          nxt_mst     = SORM_M_FIRST;
          nxt_first_a = mute_a;
          nxt_mwin    = '0;
        end
      end
      SORM_M_FIRST: begin
        nxt_mwin = mwin_ff + 1'b1;
        if (!(first_a_ff ? mute_a : mute_b)) begin
          nxt_mst = SORM_M_IDLE;
        end else if (mute_a && mute_b) begin
          nxt_mst = SORM_M_MUTED;
          ev_mute = 1'b1;
        end else if (mwin_ff == MW'(MWIN_CYC - 1)) begin
          nxt_mst = SORM_M_BAD;
          ev_bad  = 1'b1;
        end
      end
      SORM_M_MUTED: begin
        if (!mute_a || !mute_b) begin
          nxt_mst = SORM_M_IDLE;
        end
      end
      default: begin
        // Bad sequence: override window, otherwise wait for sensors clear
        if (ovr_en && override_key && !ovr_active && !lockout) begin
          nxt_ovr = OW'(OVR_CYC);
        end
        if (!mute_a && !mute_b && !ovr_active) begin
          nxt_mst = SORM_M_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mst_ff     <= SORM_M_IDLE;
      mwin_ff    <= '0;
      first_a_ff <= 1'b0;
      ovr_ff     <= '0;
    end else begin
      mst_ff     <= nxt_mst;
      mwin_ff    <= nxt_mwin;
      first_a_ff <= nxt_first_a;
      ovr_ff     <= nxt_ovr;
    end
  end

  // Effective intrusion: muting or override masks the field
  logic intrude;
  assign intrude = field_blocked & ~muted & ~ovr_active;

  // Restart state machine
  sorm_state_t st_ff, nxt_st;
  logic ev_trip, ev_on;
  always_comb begin
    nxt_st  = st_ff;
    ev_trip = 1'b0;
    ev_on   = 1'b0;
    case (st_ff)
      SORM_RUN: begin
        if (lockout) begin
          nxt_st  = SORM_LOCKED;
          ev_trip = 1'b1;
        end else if (intrude || !fb_closed) begin
          nxt_st  = SORM_OFF_WAIT;
          ev_trip = 1'b1;
        end
      end
      SORM_LOCKED: begin
        if (!lockout) begin
          nxt_st = SORM_OFF_WAIT;
        end
      end
      SORM_OFF_WAIT: begin
        if (lockout) begin
          nxt_st = SORM_LOCKED;
        end else if (!intrude && fb_closed && !manual_mode) begin
          nxt_st = SORM_RUN;
          ev_on  = 1'b1;
        end else if (!intrude && manual_mode && !btn) begin
          nxt_st = SORM_ARMED;
        end
      end
      SORM_ARMED: begin
        if (lockout) begin
          nxt_st = SORM_LOCKED;
        end else if (intrude || !manual_mode) begin
          nxt_st = SORM_OFF_WAIT;
        end else if (btn) begin
          nxt_st = SORM_BTN_DOWN;
        end
      end
      SORM_BTN_DOWN: begin
        if (lockout) begin
          nxt_st = SORM_LOCKED;
        end else if (intrude) begin
          nxt_st = SORM_OFF_WAIT;
        end else if (!btn && fb_closed) begin
          nxt_st = SORM_RUN;
          ev_on  = 1'b1;
        end else if (!btn) begin
          nxt_st = SORM_ARMED;
        end
      end
      default: nxt_st = SORM_OFF_WAIT;
    endcase
  end

  // Registered outputs
  logic [1:0] nxt_pair;
  logic       nxt_aux, nxt_lamp;
  assign nxt_pair = (nxt_st == SORM_RUN) ? 2'h3 : 2'h0;
  assign nxt_lamp = (nxt_mst == SORM_M_MUTED) | (nxt_ovr != '0);
  // Aux: mirror mode or muting/diagnostic (lit solid on lockout/bad seq)
  assign nxt_aux  = aux_mode ? (nxt_lamp | lockout | (nxt_mst == SORM_M_BAD))
                             : (nxt_st == SORM_RUN);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff              <= SORM_OFF_WAIT;
      safety_output_pair <= 2'h0;
      aux_output         <= 1'b0;
      muting_lamp        <= 1'b0;
    end else begin
      st_ff              <= nxt_st;
      safety_output_pair <= nxt_pair;
      aux_output         <= nxt_aux;
      muting_lamp        <= nxt_lamp;
    end
  end

  // Sticky events; a read of the event register clears, set wins
  logic [SORM_EV_W-1:0] ev_ff, nxt_ev, mask_ff, nxt_mask, ev_in;
  logic fb_open_q_ff;
  assign ev_in = {~fb_closed & fb_open_q_ff, ev_bad, ev_mute, ev_on, ev_trip};

  // AHB-Lite slave, zero wait states
  logic        ap_ff, nxt_ap, wr_ff, nxt_wr;
  logic [7:0]  ad_ff, nxt_ad;
  logic [31:0] nxt_rdata;
  logic        ap_ok;
  assign ap_ok = hsel & hready & htrans[1];
  always_comb begin
    nxt_ap    = ap_ok;
    nxt_wr    = hwrite;
    nxt_ad    = haddr[7:0];
    nxt_ctrl  = ctrl_ff;
    nxt_mask  = mask_ff;
    nxt_ev    = ev_ff;
    nxt_rdata = 32'h0000_0000;
    if (ap_ff && wr_ff) begin
      if (ad_ff == SORM_CTRL_OFF) begin
        nxt_ctrl = hwdata[3:0];
      end else if (ad_ff == SORM_MASK_OFF) begin
        nxt_mask = hwdata[SORM_EV_W-1:0];
      end
    end
    if (ap_ok && !hwrite) begin
      if (haddr[7:0] == SORM_CTRL_OFF) begin
        nxt_rdata = {28'h0, ctrl_ff};
      end else if (haddr[7:0] == SORM_STATUS_OFF) begin
        nxt_rdata = {24'h0, 1'b0, mst_ff, st_ff, fb_closed, lockout};
      end else if (haddr[7:0] == SORM_EVENT_OFF) begin
        nxt_rdata = {27'h0, ev_ff};
        nxt_ev    = '0;
      end else if (haddr[7:0] == SORM_MASK_OFF) begin
        nxt_rdata = {27'h0, mask_ff};
      end
    end
    nxt_ev = nxt_ev | ev_in;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_ff        <= 1'b0;
      wr_ff        <= 1'b0;
      ad_ff        <= 8'h00;
      ctrl_ff      <= SORM_CTRL_RST;
      mask_ff      <= SORM_EV_RST;
      ev_ff        <= SORM_EV_RST;
      fb_open_q_ff <= 1'b0;
      hrdata       <= 32'h0000_0000;
      irq          <= 1'b0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      ap_ff        <= nxt_ap;
      wr_ff        <= nxt_wr;
      ad_ff        <= nxt_ad;
      ctrl_ff      <= nxt_ctrl;
      mask_ff      <= nxt_mask;
      ev_ff        <= nxt_ev;
      fb_open_q_ff <= fb_closed;
      hrdata       <= nxt_rdata;
      irq          <= |(nxt_ev & nxt_mask);
      // Always ready, always OKAY; kept in flops so every output is registered
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end
endmodule

// file: core/sorm_pkg.sv
// Constants and types for the safety output restart and muting controller.
// Assumes a single 10 MHz clock and an AHB-Lite register bus.
package sorm_pkg;
  // Register byte offsets
  localparam logic [7:0] SORM_CTRL_OFF   = 8'h00;
  localparam logic [7:0] SORM_STATUS_OFF = 8'h04;
  localparam logic [7:0] SORM_EVENT_OFF  = 8'h08;
  localparam logic [7:0] SORM_MASK_OFF   = 8'h0C;
  // Control fields
  localparam int SORM_CTRL_MANUAL_BIT  = 0;
  localparam int SORM_CTRL_FOURSEN_BIT = 1;
  localparam int SORM_CTRL_AUXMODE_BIT = 2;
  localparam int SORM_CTRL_OVR_BIT     = 3;
  localparam logic [3:0] SORM_CTRL_RST = 4'h0;
  // Event bits
  localparam int SORM_EV_TRIP   = 0;
  localparam int SORM_EV_ON     = 1;
  localparam int SORM_EV_MUTE   = 2;
  localparam int SORM_EV_BADSEQ = 3;
  localparam int SORM_EV_FBOPEN = 4;
  localparam int SORM_EV_W      = 5;
  localparam logic [4:0] SORM_EV_RST = 5'h00;
  // Timing
  localparam int SORM_CLK_HZ      = 10_000_000;
  localparam int SORM_DEB_US      = 5_000;
  localparam int SORM_DEB_CYC     = SORM_DEB_US * (SORM_CLK_HZ / 1_000_000);
  localparam int SORM_MUTE_WIN_MS = 4_000;
  localparam int SORM_MUTE_WIN_CYC = SORM_MUTE_WIN_MS * (SORM_CLK_HZ / 1_000);
  localparam int SORM_OVR_MS      = 60_000;
  localparam int SORM_OVR_CYC     = SORM_OVR_MS * (SORM_CLK_HZ / 1_000);
  typedef enum logic [2:0] {
    SORM_OFF_WAIT = 3'b000,
    SORM_ARMED    = 3'b001,
    SORM_BTN_DOWN = 3'b010,
    SORM_RUN      = 3'b011,
    SORM_LOCKED   = 3'b100
  } sorm_state_t;
  typedef enum logic [1:0] {
    SORM_M_IDLE  = 2'b00,
    SORM_M_FIRST = 2'b01,
    SORM_M_MUTED = 2'b10,
    SORM_M_BAD   = 2'b11
  } sorm_mute_t;
endpackage

// file: verif/sorm_ctrl_bench.sv
// Bench for sorm_ctrl with the far-side model and an AHB-Lite master.
// Assumes short debounce, muting window and override counts.
`timescale 1ns/1ps
module sorm_ctrl_bench;
  import sorm_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, press, stuck, four;
  logic        field_blocked, lockout, override_key, hreadyout, hresp;
  logic        restart_button, contactor_feedback_loop, aux_output, muting_lamp, irq;
  logic [1:0]  htrans, sens, safety_output_pair;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  muting_sensor;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          m_on = 0;
  initial {hclk, hresetn, hsel, hwrite, press, stuck, four, field_blocked} = '0;
  initial {lockout, override_key, htrans, sens, haddr, hwdata} = '0;
  // Free-running 10 MHz clock
  always #50 hclk = ~hclk;
  sorm_ctrl #(.DEB_CYC(4), .MWIN_CYC(20), .OVR_CYC(50)) u_sorm_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .field_blocked, .lockout, .restart_button,
    .contactor_feedback_loop, .muting_sensor, .override_key, .safety_output_pair,
    .aux_output, .muting_lamp, .irq);
  sorm_far_side u_sorm_far_side (.hclk, .press, .stuck, .four, .sens, .restart_button,
    .contactor_feedback_loop, .muting_sensor);
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Single word transfer; read data is taken at the closing edge
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    {hsel, hwrite, htrans, haddr} <= {1'h1, wr, 2'h2, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // Model outputs follow m_on; latency is bounded, not fixed
  task automatic settle();
    for (int i = 0; i < 40 && safety_output_pair !== (m_on ? 2'h3 : 2'h0); i++)
      @(posedge hclk);
    chk(safety_output_pair, m_on ? 2'h3 : 2'h0);
  endtask
  // Random hold time, always longer than the debounce
  task automatic push();
    press <= 1'h1;
    wt(8 + $urandom % 8);
    press <= 1'h0;
    wt(12);
  endtask
  initial begin
    #(6000 * 100);
    n_mismatch++;
    results();
  end
  initial begin
    rdv = $urandom(26234);
    wt(3);
    hresetn <= 1'h1;
    wt(1);
    // Reset values, unmapped place ignored, trip unmasked
    xfer(SORM_CTRL_OFF, 1'h0, 32'h0, rdv);
    chk(rdv, 32'h0);
    xfer(8'h10, 1'h1, 32'hFF, rdv);
    xfer(8'h10, 1'h0, 32'h0, rdv);
    chk(rdv, 32'h0);
    xfer(SORM_MASK_OFF, 1'h1, 32'h1 << SORM_EV_TRIP, rdv);
    m_on = 1;
    settle();
    chk(aux_output, m_on);
    // Trip raises irq; a read of events clears it
    field_blocked <= 1'h1;
    m_on = 0;
    settle();
    wt(2);
    chk(irq, 1);
    xfer(SORM_EVENT_OFF, 1'h0, 32'h0, rdv);
    chk(rdv[SORM_EV_TRIP], 1);
    field_blocked <= 1'h0;
    m_on = 1;
    settle();
    chk(irq, 0);
    // Welded contactor trips and blocks every restart
    stuck <= 1'h1;
    m_on = 0;
    settle();
    field_blocked <= 1'h1;
    wt(5);
    field_blocked <= 1'h0;
    wt(30);
    chk(safety_output_pair, 0);
    stuck <= 1'h0;
    m_on = 1;
    settle();
    // Manual mode: press refused while blocked, open or locked
    xfer(SORM_CTRL_OFF, 1'h1, 32'h1, rdv);
    field_blocked <= 1'h1;
    m_on = 0;
    settle();
    push();
    field_blocked <= 1'h0;
    wt(30);
    chk(safety_output_pair, 0);
    stuck <= 1'h1;
    wt(12);
    push();
    chk(safety_output_pair, 0);
    {stuck, lockout} <= 2'h1;
    wt(12);
    push();
    chk(safety_output_pair, 0);
    lockout <= 1'h0;
    press <= 1'h1;
    wt(12);
    chk(safety_output_pair, 0);
    press <= 1'h0;
    m_on = 1;
    settle();
    // Ordered sensors mute the field in both wirings
    for (int f = 0; f < 2; f++) begin
      xfer(SORM_CTRL_OFF, 1'h1, f << SORM_CTRL_FOURSEN_BIT, rdv);
      four <= f[0];
      sens <= 2'h1;
      wt(10);
      sens <= 2'h3;
      wt(12);
      chk(muting_lamp, 1);
      field_blocked <= 1'h1;
      wt(10);
      chk(safety_output_pair, 3);
      sens <= 2'h2;
      wt(12);
      chk(muting_lamp, 0);
      m_on = 0;
      settle();
      {field_blocked, sens} <= '0;
      m_on = 1;
      settle();
    end
    // Simultaneous sensors refused; override lights the lamp
    xfer(SORM_CTRL_OFF, 1'h1, 32'hE, rdv);
    sens <= 2'h3;
    wt(12);
    chk(muting_lamp, 0);
    chk(aux_output, 1);
    field_blocked <= 1'h1;
    m_on = 0;
    settle();
    override_key <= 1'h1;
    wt(6);
    chk(muting_lamp, 1);
    results();
  end
endmodule

// file: verif/sorm_ctrl_chk.sv
// Port checker for the restart and muting controller.
// Assumes it is bound onto sorm_ctrl and inherits its counts.
`timescale 1ns/1ps
module sorm_ctrl_chk #(
  parameter int DEB_CYC  = 4,
  parameter int MWIN_CYC = 20,
  parameter int OVR_CYC  = 50
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        field_blocked,
  input wire logic        lockout,
  input wire logic        contactor_feedback_loop,
  input wire logic [3:0]  muting_sensor,
  input wire logic        override_key,
  input wire logic [1:0]  safety_output_pair,
  input wire logic        muting_lamp,
  input wire logic        irq
);
  int open_cnt;
  int idle_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Run lengths of an open loop and of idle sensors; margin covers sync and debounce
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_cnt <= 0;
      idle_cnt <= 0;
    end else begin
      open_cnt <= contactor_feedback_loop ? 0 : open_cnt + 1;
      idle_cnt <= (|muting_sensor || override_key) ? 0 : idle_cnt + 1;
    end
  end
  a_field_trips: assert property (
    field_blocked && !muting_lamp |-> ##[1:2] safety_output_pair == 2'h0)
    else $error("outputs stay on with field blocked");
  a_pair_equal: assert property (
    safety_output_pair[0] == safety_output_pair[1])
    else $error("safety outputs disagree");
  a_lock_trips: assert property (
    lockout |-> ##[1:2] safety_output_pair == 2'h0)
    else $error("outputs on during lockout");
  a_loop_holds: assert property (
    open_cnt > DEB_CYC + 6 |-> safety_output_pair == 2'h0)
    else $error("outputs on with feedback loop open");
  a_on_clear: assert property (
    $rose(safety_output_pair[0]) |->
    (!$past(field_blocked) || $past(muting_lamp)) && !$past(lockout))
    else $error("outputs rose with field blocked or locked");
  a_lamp_idle: assert property (
    idle_cnt > DEB_CYC + OVR_CYC + 8 |-> !muting_lamp)
    else $error("lamp on with sensors released");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered error");
  a_rdata_quiet: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  c_lamp: cover property ($rose(muting_lamp));
  c_on: cover property ($rose(safety_output_pair[0]));
  c_irq: cover property ($rose(irq));
endmodule
bind sorm_ctrl sorm_ctrl_chk #(.DEB_CYC(DEB_CYC), .MWIN_CYC(MWIN_CYC), .OVR_CYC(OVR_CYC)) u_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .field_blocked, .lockout, .contactor_feedback_loop, .muting_sensor, .override_key,
  .safety_output_pair, .muting_lamp, .irq);

// file: verif/sorm_far_side.sv
// Far side: restart push-button, contactors with feedback, muting sensors.
// Assumes bench commands; every line changes just after a rising edge.
`timescale 1ns/1ps
module sorm_far_side (
  input  wire logic       hclk,
  input  wire logic       press,
  input  wire logic       stuck,
  input  wire logic       four,
  input  wire logic [1:0] sens,
  output logic            restart_button,
  output logic            contactor_feedback_loop,
  output logic [3:0]      muting_sensor
);
  logic [1:0] lag_ff;
  initial {restart_button, contactor_feedback_loop, muting_sensor, lag_ff} = '0;
  // Normally open contact: high only while held
  always @(posedge hclk) restart_button <= press;
  // Welded contactor keeps the loop open; contacts lag three cycles
  always @(posedge hclk) begin
    lag_ff <= {lag_ff[0], ~stuck};
    contactor_feedback_loop <= lag_ff[1];
  end
  // Four-sensor wiring uses the paralleled pair, the other pair stays low
  always @(posedge hclk) muting_sensor <= four ? {sens, 2'h0} : {2'h0, sens};
endmodule
